// >>> common/pcl_defines.svh
// Command codes, status bit positions, fixed values and hysteresis divisors.
`ifndef PCL_DEFINES_SVH
`define PCL_DEFINES_SVH
`define PCL_CMD_PAGE      8'h00
`define PCL_CMD_CLEAR     8'h03
`define PCL_CMD_GUARD     8'h10
`define PCL_CMD_STORE     8'h11
`define PCL_CMD_RESTORE   8'h12
`define PCL_CMD_CAP       8'h19
`define PCL_CMD_FORMAT    8'h20
`define PCL_CMD_SCALE     8'h2A
`define PCL_CMD_GAIN      8'h38
`define PCL_CMD_OVF       8'h40
`define PCL_CMD_OVW       8'h42
`define PCL_CMD_UVW       8'h43
`define PCL_CMD_UVF       8'h44
`define PCL_CMD_OCW       8'h46
`define PCL_CMD_SBYTE     8'h78
`define PCL_CMD_SWORD     8'h79
`define PCL_CMD_SVOUT     8'h7A
`define PCL_CMD_SMFR      8'h80
`define PCL_GUARD_ALL     8'h80
`define PCL_GUARD_PAGE    8'h40
`define PCL_GUARD_NONE    8'h00
`define PCL_CAP_VALUE     8'h00
`define PCL_FORMAT_VALUE  8'h40
`define PCL_SB_VOUT_OV    5
`define PCL_SB_CML        1
`define PCL_SB_NONE       0
`define PCL_SW_VOUT       15
`define PCL_SW_MFR        12
`define PCL_SV_OVF        7
`define PCL_SV_OVW        6
`define PCL_SV_UVW        5
`define PCL_SV_UVF        4
`define PCL_SM_OCW        1
`define PCL_DIV_VOLT      17'h00032
`define PCL_DIV_CURR      17'h00014
`define PCL_SCALE_FULL    16'h7FFF
`endif

// >>> common/pcl_pkg.sv
// Types shared by the command layer and its surroundings.
package pcl_pkg;
    // Configuration image held in working registers and in flash.
    typedef struct packed {
        logic [15:0]      scale;  // Voltage ratio, count over 7FFFh.
        logic [15:0]      gain;   // Current gain, 0.1 milliohm per count.
        logic [4:0][15:0] lim;    // 0 ovf, 1 ovw, 2 uvw, 3 uvf, 4 ocw.
    } pcl_cfg_t;
    // One decoded command from the serial front end.
    typedef struct packed {
        logic [7:0]  code;
        logic        wr;
        logic [15:0] data;        // Word data, first bus byte in [7:0].
    } pcl_cmd_t;
    // Read answer.
    typedef struct packed {
        logic        ok;
        logic        two;         // Two bytes: send [7:0] then [15:8].
        logic [15:0] data;
    } pcl_rsp_t;
    typedef enum logic [3:0] {
        PCL_ST_LOAD    = 4'h1,
        PCL_ST_IDLE    = 4'h2,
        PCL_ST_STORE   = 4'h4,
        PCL_ST_RESTORE = 4'h8
    } pcl_state_t;
endpackage

// >>> design/pcl_cmd_layer.sv
// Configuration, protection and limit command layer of a supply monitor.
//
// Operation
// - Clear-faults clears all latched status at once.
// - Still-present conditions set status again immediately.
// - Guard byte 80h/40h/00h selects allowed writes.
// - Reads are served whatever the guard setting.
// - Guarded writes are dropped without any status.
// - Store-all saves configuration only; failure sets CML.
// - No command is answered during flash copy.
// - Restore-all loads flash; also runs after reset.
// - Feature_summary byte reads all zero.
// - Format reads 40h; writing it sets CML.
// - Scale value over 32767 gives ADC ratio.
// - Gain counts are 0.1 milliohm each.
// - Overvoltage fault sets its status bit set.
// - Overvoltage clears only 2% below limit.
// - Overvoltage detection masked until first below limit.
// - Overvoltage warning sets its status bit set.
// - Undervoltage warning sets its status bit set.
// - Undervoltage fault sets its status bit set.
// - Undervoltage masked until above; clears 2% above.
// - Overcurrent warning sets its status bit set.
// - Overcurrent masked until below; clears 5% below.
// - Reset pin clears latched status too.
// - Command unsupported on page sets CML.
`timescale 1ns/1ps
`include "pcl_defines.svh"
module pcl_cmd_layer (
    input  wire logic              clock,
    input  wire logic              ce,
    input  wire logic              arst_n,
    input  wire logic              cmd_valid,
    input  wire pcl_pkg::pcl_cmd_t cmd,
    input  wire logic              page_ok,
    input  wire logic              volt_valid,
    input  wire logic [15:0]       volt_value,
    input  wire logic              curr_valid,
    input  wire logic [15:0]       curr_value,
    input  wire logic              flash_done,
    input  wire logic              flash_err,
    input  wire pcl_pkg::pcl_cfg_t flash_rdata,
    output logic                   rsp_valid,
    output pcl_pkg::pcl_rsp_t      rsp,
    output logic                   busy,
    output logic                   flash_req,
    output logic                   flash_wr,
    output pcl_pkg::pcl_cfg_t      flash_wdata,
    output logic [15:0]            vscale,
    output logic [15:0]            igain,
    output logic [4:0]             limit_event,
    output logic [15:0]            status_word
);
    pcl_pkg::pcl_state_t state_ff;      // Flash copy sequencer.
    pcl_pkg::pcl_cfg_t   cfg_ff;        // Working configuration.
    pcl_pkg::pcl_cfg_t   wimg_ff;       // Image handed to flash.
    logic [7:0]          guard_ff;      // Write guard level.
    logic [4:0]          armed_ff;      // Limit has passed once.
    logic [4:0]          act_ff;        // Limit condition present.
    logic [7:0]          sts_vout_ff;   // Latched voltage status.
    logic [7:0]          sts_mfr_ff;    // Latched maker status.
    logic                cml_ff;        // Latched command fault.
    logic                req_ff;
    logic                wr_ff;
    logic                rsp_valid_ff;
    pcl_pkg::pcl_rsp_t   rsp_ff;
    logic [15:0]         sword_ff;
    // Decoder results, valid in the cycle a command is taken.
    logic                take;
    logic                blocked;
    logic                do_clr;
    logic                do_guard;
    logic                do_store;
    logic                do_restore;
    logic                do_cfg;
    logic [2:0]          cfg_idx;
    logic                cfg_hit;
    logic                cml_cmd;
    logic                rd_ok;
    logic                rd_two;
    logic [15:0]         rd_data;
    logic [15:0]         sword;
    logic                flash_fail;
    logic [7:0]          nxt_sts_vout;
    logic [7:0]          nxt_sts_mfr;
    logic                nxt_cml;

    // Commands are ignored outright while flash is being copied.
    assign take = cmd_valid && (state_ff == pcl_pkg::PCL_ST_IDLE);

    // Map a word command to its slot; limit k sits at index 6 - k.
    always_comb begin
        cfg_idx = 3'h0;
        cfg_hit = 1'b1;
        case (cmd.code)
            `PCL_CMD_SCALE: cfg_idx = 3'h0;
            `PCL_CMD_GAIN:  cfg_idx = 3'h1;
            `PCL_CMD_OVF:   cfg_idx = 3'h6;
            `PCL_CMD_OVW:   cfg_idx = 3'h5;
            `PCL_CMD_UVW:   cfg_idx = 3'h4;
            `PCL_CMD_UVF:   cfg_idx = 3'h3;
            `PCL_CMD_OCW:   cfg_idx = 3'h2;
            default:        cfg_hit = 1'b0;
        endcase
    end

    // Guard policy; the page command itself is served elsewhere.
    always_comb begin
        case (guard_ff)
            `PCL_GUARD_ALL:  blocked = cmd.code != `PCL_CMD_GUARD;
            `PCL_GUARD_PAGE: blocked = (cmd.code != `PCL_CMD_GUARD) &&
                                       (cmd.code != `PCL_CMD_PAGE);
            default:         blocked = 1'b0;
        endcase
    end

    // Write decode. A guarded write falls out with no flag at all.
    always_comb begin
        do_clr     = 1'b0;
        do_guard   = 1'b0;
        do_store   = 1'b0;
        do_restore = 1'b0;
        do_cfg     = 1'b0;
        cml_cmd    = 1'b0;
        if (take && cmd.wr && !blocked) begin
            if (cmd.code == `PCL_CMD_CLEAR) begin
                do_clr = 1'b1;
            end else if (cmd.code == `PCL_CMD_GUARD) begin
                // Only the three defined levels are taken.
                do_guard = (cmd.data[7:0] == `PCL_GUARD_ALL) ||
                           (cmd.data[7:0] == `PCL_GUARD_PAGE) ||
                           (cmd.data[7:0] == `PCL_GUARD_NONE);
                cml_cmd  = !do_guard;
            end else if (cmd.code == `PCL_CMD_STORE) begin
                do_store = 1'b1;
            end else if (cmd.code == `PCL_CMD_RESTORE) begin
                do_restore = 1'b1;
            end else if (cmd.code == `PCL_CMD_PAGE) begin
                cml_cmd = 1'b0;
            end else if (cfg_hit && page_ok) begin
                do_cfg = 1'b1;
            end else begin
                // Read-only codes, unknown codes and codes unsupported on
                // the current page all land here.
                cml_cmd = 1'b1;
            end
        end
        if (take && !cmd.wr && !rd_ok) begin
            cml_cmd = 1'b1;
        end
    end

    // Read decode, independent of the guard level.
    always_comb begin
        rd_ok   = 1'b1;
        rd_two  = 1'b0;
        rd_data = 16'h0000;
        if (cfg_hit) begin
            rd_ok   = page_ok;
            rd_two  = 1'b1;
            rd_data = cfg_ff[16 * (6 - cfg_idx) +: 16];
        end else begin
            case (cmd.code)
                `PCL_CMD_GUARD:  rd_data = {8'h00, guard_ff};
                `PCL_CMD_CAP:    rd_data = {8'h00, `PCL_CAP_VALUE};
                `PCL_CMD_FORMAT: rd_data = {8'h00, `PCL_FORMAT_VALUE};
                `PCL_CMD_SBYTE:  rd_data = {8'h00, sword[7:0]};
                `PCL_CMD_SVOUT:  rd_data = {8'h00, sts_vout_ff};
                `PCL_CMD_SMFR:   rd_data = {8'h00, sts_mfr_ff};
                `PCL_CMD_SWORD: begin
                    rd_two  = 1'b1;
                    rd_data = sword;
                end
                default:         rd_ok = 1'b0;
            endcase
        end
    end

    // Summary word built from the latched detail bits.
    always_comb begin
        sword                 = 16'h0000;
        sword[`PCL_SB_VOUT_OV] = sts_vout_ff[`PCL_SV_OVF];
        sword[`PCL_SB_CML]     = cml_ff;
        sword[`PCL_SB_NONE]    = sts_vout_ff[`PCL_SV_OVW] |
                                 sts_vout_ff[`PCL_SV_UVW] |
                                 sts_vout_ff[`PCL_SV_UVF] |
                                 sts_mfr_ff[`PCL_SM_OCW];
        sword[`PCL_SW_VOUT]    = |sts_vout_ff;
        sword[`PCL_SW_MFR]     = |sts_mfr_ff;
    end

    // Flash copy sequencer. Reset starts with a load from flash, so the
    // working set comes up from the saved image unless that load fails.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= pcl_pkg::PCL_ST_LOAD;
            req_ff   <= 1'b1;
            wr_ff    <= 1'b0;
            wimg_ff  <= '0;
        end else if (ce) begin
            case (state_ff)
                pcl_pkg::PCL_ST_IDLE: begin
                    if (do_store) begin
                        // Only configuration goes to flash, never status.
                        wimg_ff  <= cfg_ff;
                        req_ff   <= 1'b1;
                        wr_ff    <= 1'b1;
                        state_ff <= pcl_pkg::PCL_ST_STORE;
                    end else if (do_restore) begin
                        req_ff   <= 1'b1;
                        wr_ff    <= 1'b0;
                        state_ff <= pcl_pkg::PCL_ST_RESTORE;
                    end
                end
                pcl_pkg::PCL_ST_LOAD,
                pcl_pkg::PCL_ST_STORE,
                pcl_pkg::PCL_ST_RESTORE: begin
                    if (flash_done) begin
                        req_ff   <= 1'b0;
                        wr_ff    <= 1'b0;
                        state_ff <= pcl_pkg::PCL_ST_IDLE;
                    end
                end
                default: begin
                    req_ff   <= 1'b0;
                    state_ff <= pcl_pkg::PCL_ST_IDLE;
                end
            endcase
        end
    end

    // A finished copy that reports an error raises CML.
    assign flash_fail = flash_done && flash_err &&
                        (state_ff != pcl_pkg::PCL_ST_IDLE);

    // Working configuration: host writes and loads from flash. A failed
    // load keeps the old values rather than taking a half-read image.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg_ff <= '0;
        end else if (ce) begin
            if (flash_done && !flash_err && !wr_ff &&
                state_ff != pcl_pkg::PCL_ST_IDLE) begin
                cfg_ff <= flash_rdata;
            end else if (do_cfg) begin
                cfg_ff[16 * (6 - cfg_idx) +: 16] <= cmd.data;
            end
        end
    end

    // Write guard level; it is volatile and resets to open.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            guard_ff <= `PCL_GUARD_NONE;
        end else if (ce && do_guard) begin
            guard_ff <= cmd.data[7:0];
        end
    end

    // Per-limit detection: masking, trip and hysteresis release.
    // Slots 0, 1 and 4 trip above; 2 and 3 trip below.
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_lim
            localparam bit       OVER = (gi == 0) || (gi == 1) || (gi == 4);
            localparam bit       CURR = (gi == 4);
            localparam [16:0]    DIV  = CURR ? `PCL_DIV_CURR : `PCL_DIV_VOLT;
            logic [15:0] lim;
            logic [15:0] smp;
            logic        vld;
            logic [16:0] margin;
            logic        trip;
            logic        rel;
            logic        arm;
            assign lim    = cfg_ff.lim[gi];
            assign smp    = CURR ? curr_value : volt_value;
            assign vld    = CURR ? curr_valid : volt_valid;
            // Margin rounds up so the release is never short of the percent.
            assign margin = ({1'b0, lim} + DIV - 17'h00001) / DIV;
            assign trip   = OVER ? (smp > lim) : (smp < lim);
            assign rel    = OVER ? ({1'b0, smp} <= {1'b0, lim} - margin)
                                 : ({1'b0, smp} >= {1'b0, lim} + margin);
            assign arm    = OVER ? (smp < lim) : (smp > lim);
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    armed_ff[gi] <= 1'b0;
                    act_ff[gi]   <= 1'b0;
                end else if (ce && vld) begin
                    if (!armed_ff[gi]) begin
                        armed_ff[gi] <= arm;
                    end else if (trip) begin
                        act_ff[gi] <= 1'b1;
                    end else if (rel) begin
                        act_ff[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Latched status. Clear and a still-present condition in the same
    // cycle leave the bit set, so nothing is lost.
    always_comb begin
        nxt_sts_vout = do_clr ? 8'h00 : sts_vout_ff;
        nxt_sts_mfr  = do_clr ? 8'h00 : sts_mfr_ff;
        nxt_cml      = (do_clr ? 1'b0 : cml_ff) | cml_cmd | flash_fail;
        nxt_sts_vout[`PCL_SV_OVF] = nxt_sts_vout[`PCL_SV_OVF] | act_ff[0];
        nxt_sts_vout[`PCL_SV_OVW] = nxt_sts_vout[`PCL_SV_OVW] | act_ff[1];
        nxt_sts_vout[`PCL_SV_UVW] = nxt_sts_vout[`PCL_SV_UVW] | act_ff[2];
        nxt_sts_vout[`PCL_SV_UVF] = nxt_sts_vout[`PCL_SV_UVF] | act_ff[3];
        nxt_sts_mfr[`PCL_SM_OCW]  = nxt_sts_mfr[`PCL_SM_OCW] | act_ff[4];
    end

    // Status registers; the reset pin also wipes them.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sts_vout_ff <= 8'h00;
            sts_mfr_ff  <= 8'h00;
            cml_ff      <= 1'b0;
        end else if (ce) begin
            sts_vout_ff <= nxt_sts_vout;
            sts_mfr_ff  <= nxt_sts_mfr;
            cml_ff      <= nxt_cml;
        end
    end

    // Read answer, one cycle after the command is taken.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid_ff <= 1'b0;
            rsp_ff       <= '0;
        end else if (ce) begin
            rsp_valid_ff <= take && !cmd.wr;
            if (take && !cmd.wr) begin
                rsp_ff.ok   <= rd_ok;
                rsp_ff.two  <= rd_two;
                rsp_ff.data <= rd_ok ? rd_data : 16'h0000;
            end
        end
    end

    // Registered copy of the summary word for the fault response logic.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sword_ff <= 16'h0000;
        end else if (ce) begin
            sword_ff <= sword;
        end
    end

    // Scale and gain feed the converter math unchanged: the ratio is the
    // count over 7FFFh, the gain one count per 0.1 milliohm.
    assign vscale      = cfg_ff.scale;
    assign igain       = cfg_ff.gain;
    assign rsp_valid   = rsp_valid_ff;
    assign rsp         = rsp_ff;
    assign busy        = state_ff != pcl_pkg::PCL_ST_IDLE;
    assign flash_req   = req_ff;
    assign flash_wr    = wr_ff;
    assign flash_wdata = wimg_ff;
    // Live conditions go to the fault reaction setting logic.
    assign limit_event = act_ff;
    assign status_word = sword_ff;
endmodule // pcl_cmd_layer

// >>> test/pcl_cmd_layer_monitor.sv
// Concurrent checks on the command layer ports.
`timescale 1ns/1ps
module pcl_cmd_layer_monitor (
    input wire logic              clock,
    input wire logic              ce,
    input wire logic              arst_n,
    input wire logic              cmd_valid,
    input wire pcl_pkg::pcl_cmd_t cmd,
    input wire logic              busy,
    input wire logic              rsp_valid,
    input wire pcl_pkg::pcl_rsp_t rsp,
    input wire logic              flash_req,
    input wire logic              flash_done,
    input wire logic [4:0]        limit_event,
    input wire logic [15:0]       status_word
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // A command counts only when offered while the sequencer is idle.
    wire rd_take = ce && cmd_valid && !busy && !cmd.wr;
    wire wr_take = ce && cmd_valid && !busy && cmd.wr;
    // An event reaches the summary word two cycles after it rises.
    sequence s_sum(x); ##2 x; endsequence
    property p_read; rd_take |=> rsp_valid; endproperty
    a_read: assert property (p_read) else $error("read not answered");
    property p_silent; ce && cmd_valid && busy |=> !rsp_valid; endproperty
    a_silent: assert property (p_silent) else $error("answer while copying");
    property p_copy_busy; flash_req |-> busy; endproperty
    a_copy_busy: assert property (p_copy_busy) else $error("copy while idle");
    property p_copy_end; flash_req && flash_done |=> !flash_req && !busy; endproperty
    a_copy_end: assert property (p_copy_end) else $error("copy did not end");
    property p_cap; rd_take && cmd.code == 8'h19 |=> rsp == 18'h20000; endproperty
    a_cap: assert property (p_cap) else $error("feature_summary byte wrong");
    property p_fmt; rd_take && cmd.code == 8'h20 |=> rsp == 18'h20040; endproperty
    a_fmt: assert property (p_fmt) else $error("format byte wrong");
    property p_fmt_wr; wr_take && cmd.code == 8'h20 |-> ##[1:3] status_word[1]; endproperty
    a_fmt_wr: assert property (p_fmt_wr) else $error("format write kept quiet");
    property p_ovf; $rose(limit_event[0]) |-> s_sum(status_word[15] && status_word[5]); endproperty
    a_ovf: assert property (p_ovf) else $error("over fault not summed");
    property p_ovw; $rose(limit_event[1]) |-> s_sum(status_word[15] && status_word[0]); endproperty
    a_ovw: assert property (p_ovw) else $error("over warning not summed");
    property p_uvw; $rose(limit_event[2]) |-> s_sum(status_word[15] && status_word[0]); endproperty
    a_uvw: assert property (p_uvw) else $error("under warning not summed");
    property p_uvf; $rose(limit_event[3]) |-> s_sum(status_word[15] && status_word[0]); endproperty
    a_uvf: assert property (p_uvf) else $error("under fault not summed");
    property p_ocw; $rose(limit_event[4]) |-> s_sum(status_word[12] && status_word[0]); endproperty
    a_ocw: assert property (p_ocw) else $error("current warning not summed");
endmodule // pcl_cmd_layer_monitor
bind pcl_cmd_layer pcl_cmd_layer_monitor i_pcl_cmd_layer_monitor (.clock, .ce, .arst_n,
    .cmd_valid, .cmd, .busy, .rsp_valid, .rsp, .flash_req, .flash_done, .limit_event,
    .status_word);

// >>> test/pcl_flash_model.sv
// Behavioural flash that answers copy requests after a chosen number of cycles.
`timescale 1ns/1ps
module pcl_flash_model #(
    parameter pcl_pkg::pcl_cfg_t INIT = '0
) (
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic              flash_req,
    input  wire logic              flash_wr,
    input  wire pcl_pkg::pcl_cfg_t flash_wdata,
    input  wire logic [7:0]        dly,
    input  wire logic              fail,
    output logic                   flash_done,
    output logic                   flash_err,
    output pcl_pkg::pcl_cfg_t      flash_rdata
);
    pcl_pkg::pcl_cfg_t img_ff = INIT; // Nonvolatile image, so no reset branch.
    logic [7:0]        cnt_ff;        // Cycles spent on the current copy.
    // Counts the copy time and pulses done once for each request.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff     <= 8'h00;
            flash_done <= 1'b0;
        end else begin
            flash_done <= 1'b0;
            if (flash_req && !flash_done) begin
                cnt_ff     <= (cnt_ff == dly) ? 8'h00 : cnt_ff + 8'h01;
                flash_done <= (cnt_ff == dly);
            end
        end
    end
    // A failed store leaves the old image, as a real aborted program would.
    always @(posedge clock) begin
        if (flash_req && flash_wr && flash_done && !fail) begin
            img_ff <= flash_wdata;
        end
    end
    // Outside the done cycle the outputs are scrambled so nothing stale can pass.
    assign flash_rdata = flash_done ? img_ff : ~img_ff;
    assign flash_err   = flash_done ? fail : ~fail;
endmodule // pcl_flash_model

// >>> test/pcl_cmd_layer_tb.sv
// Self-checking bench for the command layer, with a flash model on its far side.
`timescale 1ns/1ps
module pcl_cmd_layer_tb;
    localparam pcl_pkg::pcl_cfg_t INIT = {16'h1999, 16'h0064, 80'h0}; // Power-up image.
    logic              clock, ce, arst_n, cmd_valid, page_ok, volt_valid, curr_valid, fail;
    logic [15:0]       volt_value, curr_value, vscale, igain, status_word;
    logic [7:0]        dly;
    logic [4:0]        limit_event;
    logic              rsp_valid, busy, flash_req, flash_wr, flash_done, flash_err;
    pcl_pkg::pcl_cmd_t cmd;
    pcl_pkg::pcl_rsp_t rsp;
    pcl_pkg::pcl_cfg_t flash_wdata, flash_rdata;
    int                error_cnt = 0;
    int                compares = 0;
    pcl_cmd_layer i_pcl_cmd_layer (.clock, .ce, .arst_n, .cmd_valid, .cmd, .page_ok,
        .volt_valid, .volt_value, .curr_valid, .curr_value, .flash_done, .flash_err,
        .flash_rdata, .rsp_valid, .rsp, .busy, .flash_req, .flash_wr, .flash_wdata,
        .vscale, .igain, .limit_event, .status_word);
    pcl_flash_model #(.INIT(INIT)) i_pcl_flash_model (.clock, .arst_n, .flash_req,
        .flash_wr, .flash_wdata, .dly, .fail, .flash_done, .flash_err, .flash_rdata);
    // Prints the verdict and ends the run.
    task automatic close_out();
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Counts each comparison and reports a mismatch at once.
    task automatic cmp(input logic [18:0] got, input logic [18:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h wanted %h", $time, got, exp);
        end
    endtask
    // Offers one command for one cycle; it is scrambled after that cycle.
    task automatic send(input logic [7:0] code, input logic wr, input logic [15:0] d);
        @(posedge clock);
        #5 cmd_valid = 1'b1;
        cmd = {code, wr, d};
        @(posedge clock);
        #5 cmd_valid = 1'b0;
        cmd = ~cmd;
    endtask
    // Lets status settle, reads, and checks the answer of the next cycle.
    task automatic rd(input logic [7:0] code, input logic two, input logic [15:0] d);
        repeat (3) @(posedge clock);
        send(code, 1'b0, 16'h0000);
        cmp({rsp_valid, rsp}, {2'b11, two, d});
    endtask
    // Waits, bounded, for the copy sequencer to fall idle.
    task automatic idle();
        repeat (400) if (busy === 1'b1) begin
            @(posedge clock);
            #5;
        end
        cmp({18'h0, busy}, 19'h0);
    endtask
    // One sample, an optional clear, then the status register and summary word.
    task automatic step(input logic c, input logic [15:0] v, input logic clr,
                        input logic [7:0] e, input logic [15:0] w);
        @(posedge clock);
        #5 {volt_valid, curr_valid, volt_value, curr_value} = {!c, c, v, v};
        @(posedge clock);
        #5 {volt_valid, curr_valid} = 2'b00;
        if (clr) send(8'h03, 1'b1, 16'h0000);
        rd(c ? 8'h80 : 8'h7A, 1'b0, {8'h00, e});
        cmp({3'b000, status_word}, {3'b000, w});
    endtask
    // Free-running clock of 50 ns.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Watchdog, far beyond the few hundred cycles the sequence needs.
    initial begin
        #400000;
        error_cnt++;
        close_out();
    end
    // Main sequence.
    initial begin
        {ce, page_ok, arst_n, cmd_valid, volt_valid, curr_valid, fail} = 7'b1100000;
        {cmd, volt_value, curr_value, dly} = '0;
        repeat (10) @(posedge clock);
        #5 arst_n = 1'b1;
        idle();
        cmp({3'b000, vscale}, {3'b000, INIT.scale});
        cmp({3'b000, igain}, {3'b000, INIT.gain});
        rd(8'h19, 1'b0, 16'h0000);
        rd(8'h20, 1'b0, 16'h0040);
        send(8'h20, 1'b1, 16'h0055);
        rd(8'h78, 1'b0, 16'h0002);
        send(8'h03, 1'b1, 16'h0000);
        rd(8'h78, 1'b0, 16'h0000);
        send(8'h2A, 1'b1, 16'h0AAB);
        rd(8'h2A, 1'b1, 16'h0AAB);
        send(8'h38, 1'b1, 16'h1388);
        cmp({3'b000, igain}, 19'h01388);
        // Both guard levels drop a scale write but still serve reads.
        for (int i = 0; i < 2; i++) begin
            send(8'h10, 1'b1, i == 0 ? 16'h0080 : 16'h0040);
            send(8'h2A, 1'b1, 16'h1234);
            send(8'h00, 1'b1, 16'h0000);
            rd(8'h10, 1'b0, i == 0 ? 16'h0080 : 16'h0040);
            rd(8'h2A, 1'b1, 16'h0AAB);
            rd(8'h78, 1'b0, 16'h0000);
        end
        send(8'h10, 1'b1, 16'h0000);
        send(8'h2A, 1'b1, 16'h1234);
        rd(8'h2A, 1'b1, 16'h1234);
        page_ok = 1'b0;
        send(8'h40, 1'b1, 16'h0001);
        rd(8'h78, 1'b0, 16'h0002);
        page_ok = 1'b1;
        send(8'h03, 1'b1, 16'h0000);
        send(8'h40, 1'b1, 16'h03E8);
        send(8'h42, 1'b1, 16'h0384);
        send(8'h43, 1'b1, 16'h01F4);
        send(8'h44, 1'b1, 16'h0190);
        send(8'h46, 1'b1, 16'h00C8);
        step(1'b0, 16'd1010, 1'b0, 8'h00, 16'h0000);
        step(1'b0, 16'd700, 1'b0, 8'h00, 16'h0000);
        step(1'b0, 16'd950, 1'b0, 8'h40, 16'h8001);
        step(1'b0, 16'd1010, 1'b0, 8'hC0, 16'h8021);
        step(1'b0, 16'd985, 1'b1, 8'hC0, 16'h8021);
        step(1'b0, 16'd980, 1'b1, 8'h40, 16'h8001);
        step(1'b0, 16'd700, 1'b1, 8'h00, 16'h0000);
        step(1'b0, 16'd450, 1'b0, 8'h20, 16'h8001);
        step(1'b0, 16'd390, 1'b0, 8'h30, 16'h8001);
        step(1'b0, 16'd500, 1'b1, 8'h20, 16'h8001);
        step(1'b0, 16'd510, 1'b1, 8'h00, 16'h0000);
        step(1'b1, 16'd250, 1'b0, 8'h00, 16'h0000);
        step(1'b1, 16'd100, 1'b0, 8'h00, 16'h0000);
        step(1'b1, 16'd250, 1'b0, 8'h02, 16'h1001);
        step(1'b1, 16'd191, 1'b1, 8'h02, 16'h1001);
        step(1'b1, 16'd190, 1'b1, 8'h00, 16'h0000);
        // Slow flash: a read offered during the copy must go unanswered.
        dly = 8'h1E;
        send(8'h11, 1'b1, 16'h0000);
        send(8'h19, 1'b0, 16'h0000);
        cmp({18'h0, rsp_valid}, 19'h0);
        idle();
        rd(8'h78, 1'b0, 16'h0000);
        send(8'h2A, 1'b1, 16'h5555);
        send(8'h12, 1'b1, 16'h0000);
        idle();
        cmp({3'b000, vscale}, 19'h01234);
        fail = 1'b1;
        send(8'h11, 1'b1, 16'h0000);
        idle();
        fail = 1'b0;
        rd(8'h78, 1'b0, 16'h0002);
        // Reset pin in mid-run: status clears and the stored image comes back.
        @(posedge clock);
        #5 arst_n = 1'b0;
        repeat (2) @(posedge clock);
        #5 arst_n = 1'b1;
        idle();
        rd(8'h78, 1'b0, 16'h0000);
        rd(8'h40, 1'b1, 16'h03E8);
        cmp({3'b000, vscale}, 19'h01234);
        close_out();
    end
endmodule // pcl_cmd_layer_tb
